// [aneg_np_pkg.sv]
// Package with offsets, field positions and reset values of the next-page registers.
package aneg_np_pkg;

	// Register offsets on the management register port.
	localparam logic [4:0] ANEG_EXP_OFFSET = 5'h06;
	localparam logic [4:0] ANEG_NPTX_OFFSET = 5'h07;
	localparam logic [4:0] ANEG_NPRX_OFFSET = 5'h08;

	// Reset values.
	localparam logic [15:0] ANEG_EXP_RESET = 16'h0004;
	localparam logic [15:0] ANEG_NPTX_RESET = 16'h2001;
	localparam logic [15:0] ANEG_NPRX_RESET = 16'h0000;

	// Expansion register field positions.
	localparam int ANEG_EXP_PD_FAULT_BIT = 4;
	localparam int ANEG_EXP_LP_NP_BIT = 3;
	localparam int ANEG_EXP_NP_ABLE_BIT = 2;
	localparam int ANEG_EXP_PAGE_RX_BIT = 1;
	localparam int ANEG_EXP_LP_AN_BIT = 0;

	// Next-page word field positions, shared by transmit and receive.
	localparam int ANEG_NP_NEXT_BIT = 15;
	localparam int ANEG_NP_MSG_BIT = 13;
	localparam int ANEG_NP_ACK2_BIT = 12;
	localparam int ANEG_NP_TOGGLE_BIT = 11;
	localparam int ANEG_NP_CODE_MSB = 10;

	// Bits of a next-page word that carry data; bit 14 is reserved.
	localparam logic [15:0] ANEG_NP_USED_MASK = 16'hBFFF;

	// Bits of the transmit register that software may write.
	localparam logic [15:0] ANEG_NPTX_WR_MASK = 16'hB7FF;

	// Local device always supports next-page exchange.
	localparam logic ANEG_LOCAL_NP_ABLE = 1'b1;

endpackage

// [aneg_latch_flag.sv]
// Status flag that is set by an event and cleared by a register read.
`timescale 1ns/1ps

module aneg_latch_flag (
	// Clock and reset.
	input  wire logic clock,
	input  wire logic rst_n,
	// Event and read-clear strobes.
	input  wire logic set_pulse,
	input  wire logic clear_pulse,
	// Latched flag.
	output logic      flag_out
);

	logic flag_reg;
	logic flag_next;

	// A set in the same cycle as the clearing read wins, so no event is lost.
	always_comb begin
		flag_next = flag_reg;
		if (clear_pulse) begin
			flag_next = 1'b0;
		end
		if (set_pulse) begin
			flag_next = 1'b1;
		end
	end

	// Register the flag.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
		end
	end

	assign flag_out = flag_reg;

endmodule

// [aneg_np_regs.sv]
// Auto-negotiation expansion and next-page register bank.
`timescale 1ns/1ps

// Summary of operation
// - Page-received and fault flags latch until read.
// - Report partner next-page ability, reset zero.
// - Local next-page able bit reads one.
// - Writable transmit acknowledge-two bit, reset zero.
// - Read-only transmit toggle, inverts each page.
// - Writable eleven-bit code sent unchanged.
// - Message-page bit selects message or unformatted.
// - Partner acknowledge-two bit shown read-only.
// - Partner page fields read-only, zero until received.
module aneg_np_regs
	import aneg_np_pkg::*;
(
	// Clock and reset.
	input  wire logic        clock,
	input  wire logic        rst_n,
	// Management register port.
	input  wire logic [4:0]  reg_addr,
	input  wire logic        reg_wr_en,
	input  wire logic [15:0] reg_wr_data,
	input  wire logic        reg_rd_en,
	output logic [15:0]      reg_rd_data,
	// Status from the arbitration logic.
	input  wire logic        an_page_rx_pulse,
	input  wire logic        an_pd_fault_pulse,
	input  wire logic        an_lp_np_able,
	input  wire logic        an_lp_an_able,
	input  wire logic        an_rx_page_valid,
	input  wire logic [15:0] an_rx_page,
	// Next page handed to the arbitration logic.
	input  wire logic        an_tx_page_taken,
	output logic [15:0]      np_tx_page,
	output logic             np_tx_pending,
	output logic             np_tx_is_message
);

	// Address match used by the read-clear decode and the write decode; the read data mux uses a case.
	function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
		hit = (a == off);
	endfunction

	logic [15:0] tx_page_reg;
	logic [15:0] tx_page_next;
	logic [15:0] rx_page_reg;
	logic [15:0] rx_page_next;
	logic        lp_np_reg;
	logic        lp_np_next;
	logic        lp_an_reg;
	logic        lp_an_next;
	logic        pending_reg;
	logic        pending_next;
	logic        msg_reg;
	logic        msg_next;
	logic [15:0] rd_data_reg;
	logic [15:0] rd_data_next;
	logic        page_rx_flag;
	logic        pd_fault_flag;
	logic        exp_read;
	logic [15:0] exp_word;

	// Reading the expansion register clears its latched flags.
	assign exp_read = reg_rd_en && hit(reg_addr, ANEG_EXP_OFFSET);

	aneg_latch_flag u_page_rx_flag (
		.clock       (clock),
		.rst_n       (rst_n),
		.set_pulse   (an_page_rx_pulse),
		.clear_pulse (exp_read),
		.flag_out    (page_rx_flag)
	);

	aneg_latch_flag u_pd_fault_flag (
		.clock       (clock),
		.rst_n       (rst_n),
		.set_pulse   (an_pd_fault_pulse),
		.clear_pulse (exp_read),
		.flag_out    (pd_fault_flag)
	);

	// Assemble the expansion word; unlisted bits stay zero.
	always_comb begin
		exp_word = 16'h0000;
		exp_word[ANEG_EXP_PD_FAULT_BIT] = pd_fault_flag;
		exp_word[ANEG_EXP_LP_NP_BIT] = lp_np_reg;
		exp_word[ANEG_EXP_NP_ABLE_BIT] = ANEG_LOCAL_NP_ABLE;
		exp_word[ANEG_EXP_PAGE_RX_BIT] = page_rx_flag;
		exp_word[ANEG_EXP_LP_AN_BIT] = lp_an_reg;
	end

	// Partner status levels follow the arbitration logic every cycle.
	always_comb begin
		lp_np_next = an_lp_np_able;
		lp_an_next = an_lp_an_able;
		rx_page_next = rx_page_reg;
		if (an_rx_page_valid) begin
			// Reserved bit 14 is dropped so it always reads zero.
			rx_page_next = an_rx_page & ANEG_NP_USED_MASK;
		end
	end

	// Transmit page: software loads it, the toggle flips as each page goes.
	always_comb begin
		tx_page_next = tx_page_reg;
		pending_next = pending_reg;
		msg_next = msg_reg;
		if (an_tx_page_taken) begin
			tx_page_next[ANEG_NP_TOGGLE_BIT] = ~tx_page_reg[ANEG_NP_TOGGLE_BIT];
			pending_next = 1'b0;
		end
		if (reg_wr_en && hit(reg_addr, ANEG_NPTX_OFFSET)) begin
			// Toggle and reserved bits are not writable.
			tx_page_next = (reg_wr_data & ANEG_NPTX_WR_MASK)
				| (tx_page_next & ~ANEG_NPTX_WR_MASK);
			pending_next = 1'b1;
			msg_next = reg_wr_data[ANEG_NP_MSG_BIT];
		end
	end

	// Read data are captured at the read strobe, before the flags clear.
	always_comb begin
		rd_data_next = rd_data_reg;
		if (reg_rd_en) begin
			case (reg_addr)
				ANEG_EXP_OFFSET:  rd_data_next = exp_word;
				ANEG_NPTX_OFFSET: rd_data_next = tx_page_reg;
				ANEG_NPRX_OFFSET: rd_data_next = rx_page_reg;
				default:          rd_data_next = 16'h0000;
			endcase
		end
	end

	// Register all state.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			tx_page_reg <= ANEG_NPTX_RESET;
			rx_page_reg <= ANEG_NPRX_RESET;
			lp_np_reg <= 1'b0;
			lp_an_reg <= 1'b0;
			pending_reg <= 1'b0;
			msg_reg <= ANEG_NPTX_RESET[ANEG_NP_MSG_BIT];
			rd_data_reg <= 16'h0000;
		end else begin
			tx_page_reg <= tx_page_next;
			rx_page_reg <= rx_page_next;
			lp_np_reg <= lp_np_next;
			lp_an_reg <= lp_an_next;
			pending_reg <= pending_next;
			msg_reg <= msg_next;
			rd_data_reg <= rd_data_next;
		end
	end

	// The code field leaves unchanged; the arbiter reads the mode flag.
	assign np_tx_page = tx_page_reg;
	assign np_tx_pending = pending_reg;
	assign np_tx_is_message = msg_reg;
	assign reg_rd_data = rd_data_reg;

endmodule

// [aneg_np_monitor.sv]
// Checker for the next-page register bank ports.
`timescale 1ns/1ps
module aneg_np_monitor
	import aneg_np_pkg::*;
(
	// Clock, reset and register port.
	input wire logic        clock, rst_n, reg_wr_en, reg_rd_en,
	input wire logic [4:0]  reg_addr,
	input wire logic [15:0] reg_wr_data, reg_rd_data, np_tx_page,
	// Arbitration side.
	input wire logic        an_tx_page_taken, np_tx_pending,
	input wire logic        np_tx_is_message
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// A write aimed at the transmit page register.
	sequence wr_tx;
		reg_wr_en && reg_addr == ANEG_NPTX_OFFSET;
	endsequence
	a_code_loaded: assert property (wr_tx |=>
		np_tx_page[10:0] == $past(reg_wr_data[10:0])) else $error("code");
	a_pend_set: assert property (wr_tx |=> np_tx_pending)
		else $error("pending");
	a_toggle_flip: assert property (an_tx_page_taken |=>
		np_tx_page[11] != $past(np_tx_page[11])) else $error("toggle");
	a_ack2_hold: assert property (!reg_wr_en |=>
		$stable(np_tx_page[12])) else $error("ack2");
	a_msg_mirror: assert property (np_tx_is_message == np_tx_page[13])
		else $error("message");
	a_tx_rsvd: assert property (np_tx_page[14] == 1'b0)
		else $error("reserved");
	a_rd_hole: assert property (reg_rd_en && reg_addr > 5'h08 |=>
		reg_rd_data == 16'h0000) else $error("hole");
	a_exp_fixed: assert property (reg_rd_en && reg_addr == 5'h06 |=>
		reg_rd_data[2] && reg_rd_data[15:5] == 11'h000) else $error("exp");
endmodule

// [aneg_arb_model.sv]
// Behavioural model of the auto-negotiation arbitration logic.
`timescale 1ns/1ps
module aneg_arb_model (
	input wire logic         clock,
	output logic             page_rx, pd_fault, lp_np, lp_an,
	output logic             rx_valid, tx_taken,
	output logic [15:0]      rx_page
);
	// Page bus carries a pattern while not valid, so stale data is caught.
	initial begin
		{page_rx, pd_fault, lp_np, lp_an, rx_valid, tx_taken} = 6'h00;
		rx_page = 16'h5a5a;
	end
	// One-cycle event pulses; partner abilities stay up.
	task automatic events();
		@(negedge clock) {page_rx, pd_fault, lp_np, lp_an} = 4'hf;
		@(negedge clock) {page_rx, pd_fault} = 2'b00;
	endtask
	// Hand over a received partner page.
	task automatic load(input logic [15:0] p);
		@(negedge clock) {rx_valid, rx_page} = {1'b1, p};
		@(negedge clock) {rx_valid, rx_page} = {1'b0, ~p};
	endtask
	// Report the local page as sent.
	task automatic take();
		@(negedge clock) tx_taken = 1'b1;
		@(negedge clock) tx_taken = 1'b0;
	endtask
endmodule

// [tb.sv]
// Testbench for the next-page register bank.
`timescale 1ns/1ps
module tb;
	import aneg_np_pkg::*;
	logic        clock, rst_n, wr_en, rd_en, prx, pdf, lpn, lpa, rxv, tk;
	logic        pend, msg;
	logic [4:0]  addr;
	logic [15:0] wdata, rdata, rxp, txp, got;
	int          fail_count, comparisons, cycles;
	aneg_np_regs i_dut (.clock(clock), .rst_n(rst_n), .reg_addr(addr),
		.reg_wr_en(wr_en), .reg_wr_data(wdata), .reg_rd_en(rd_en),
		.reg_rd_data(rdata), .an_page_rx_pulse(prx), .an_pd_fault_pulse(pdf),
		.an_lp_np_able(lpn), .an_lp_an_able(lpa), .an_rx_page_valid(rxv),
		.an_rx_page(rxp), .an_tx_page_taken(tk), .np_tx_page(txp),
		.np_tx_pending(pend), .np_tx_is_message(msg));
	aneg_arb_model i_arb (.clock(clock), .page_rx(prx), .pd_fault(pdf),
		.lp_np(lpn), .lp_an(lpa), .rx_valid(rxv), .tx_taken(tk),
		.rx_page(rxp));
	task automatic chk(input logic [15:0] e, s, input string w);
		comparisons++;
		if (s !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", w, e, s);
		end
	endtask
	// Strobes last one cycle; read data is taken once it has landed.
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge clock) {addr, wdata, wr_en} = {a, d, 1'b1};
		@(negedge clock) wr_en = 1'b0;
	endtask
	task automatic rc(input logic [4:0] a, input logic [15:0] e, string w);
		@(negedge clock) {addr, rd_en} = {a, 1'b1};
		@(negedge clock) rd_en = 1'b0;
		chk(e, rdata, w);
	endtask
	task automatic t_reset();
		rc(ANEG_EXP_OFFSET, 16'h0004, "exp");
		rc(ANEG_NPTX_OFFSET, 16'h2001, "tx");
		rc(ANEG_NPRX_OFFSET, 16'h0000, "rx");
	endtask
	task automatic t_write();
		wr(ANEG_NPTX_OFFSET, 16'hffff);
		rc(ANEG_NPTX_OFFSET, 16'hb7ff, "tx all");
		chk(16'h0001, {15'h0000, pend}, "pend");
		wr(ANEG_NPTX_OFFSET, 16'h0005);
		chk(16'h0005, txp, "page");
		chk(16'h0000, {15'h0000, msg}, "msg");
		wr(ANEG_EXP_OFFSET, 16'hffff);
		rc(ANEG_EXP_OFFSET, 16'h0004, "exp ro");
		rc(5'h1f, 16'h0000, "hole");
	endtask
	task automatic t_flags();
		i_arb.events();
		rc(ANEG_EXP_OFFSET, 16'h001f, "flags");
		rc(ANEG_EXP_OFFSET, 16'h000d, "cleared");
		// Event and clearing read in one cycle: the set must win.
		fork
			i_arb.events();
			rc(ANEG_EXP_OFFSET, 16'h000d, "race");
		join
		rc(ANEG_EXP_OFFSET, 16'h001f, "set wins");
	endtask
	task automatic t_page();
		i_arb.load(16'hffff);
		rc(ANEG_NPRX_OFFSET, 16'hbfff, "rx page");
		i_arb.take();
		rc(ANEG_NPTX_OFFSET, 16'h0805, "toggle");
		chk(16'h0000, {15'h0000, pend}, "taken");
	endtask
	task automatic report_and_stop();
		if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// A hang is cut short long after the tests should have ended.
	always @(posedge clock) begin
		cycles++;
		if (cycles == 500) begin
			fail_count++;
			report_and_stop();
		end
	end
	initial begin
		{rst_n, wr_en, rd_en, addr, wdata} = 0;
		repeat (10) @(negedge clock);
		rst_n = 1'b1;
		t_reset();
		t_write();
		t_flags();
		t_page();
		report_and_stop();
	end
endmodule
bind aneg_np_regs aneg_np_monitor i_mon (.clock(clock), .rst_n(rst_n),
	.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
	.reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
	.np_tx_page(np_tx_page), .an_tx_page_taken(an_tx_page_taken),
	.np_tx_pending(np_tx_pending), .np_tx_is_message(np_tx_is_message));
